// >>> pkg/iorsd_pkg.sv
// Constants, register map, access masks and command codes of the lower I/O register bank.
// Assumes a single clock shared with the processor core and peripherals on the same clock.
// Functional notes
// RQ1: Dedicated I/O input and output commands are decoded against the I/O range 0x00 to 0x3F.
// RQ2: Data-space loads and stores reach each I/O register at its I/O address plus 0x20.
// RQ3: Single-bit set and clear are accepted only for I/O addresses 0x00 to 0x1F.
// RQ4: Bit-accessible registers answer skip tests that check one bit for set or clear.
// RQ5: Some status flags clear when a one is written to them, and a written zero leaves them.
// RQ6: A single-bit set or clear changes only the addressed bit and writes back no other bit.
// RQ7: Software should write zero to every reserved bit position.
// RQ8: Software must never write to the reserved addresses 0x00 and 0x04 to 0x07.
// RQ9: Reserved addresses and bits read as zero and writes to them change nothing.
`default_nettype none

package iorsd_pkg;

    // ==========================================================================
    // Address spaces
    // ==========================================================================
    localparam int          DATA_W     = 8;
    localparam int          BANK_DEPTH = 32;
    localparam int          IDX_W      = 5;
    localparam logic [7:0]  IO_SPAN    = 8'h40;              // Whole I/O range
    localparam logic [7:0]  BIT_SPAN   = 8'h20;              // Bit-accessible lower half
    localparam logic [7:0]  DS_OFFSET  = 8'h20;              // Data-space view offset
    localparam logic [7:0]  DS_LIMIT   = DS_OFFSET + IO_SPAN;
    localparam logic [7:0]  ALL_BITS   = 8'hFF;
    localparam logic [7:0]  NO_BITS    = 8'h00;
    localparam logic [7:0]  RESET_VAL  = 8'h00;              // Every stored bit resets low

    // ==========================================================================
    // Register indices (I/O address)
    // ==========================================================================
    localparam logic [4:0] REG_RSVD_00     = 5'h00;
    localparam logic [4:0] REG_DIG_IN_DIS  = 5'h01;
    localparam logic [4:0] REG_BAUD_HI     = 5'h02;
    localparam logic [4:0] REG_FRAME_CFG   = 5'h03;
    localparam logic [4:0] REG_RSVD_04     = 5'h04;
    localparam logic [4:0] REG_RSVD_05     = 5'h05;
    localparam logic [4:0] REG_RSVD_06     = 5'h06;
    localparam logic [4:0] REG_RSVD_07     = 5'h07;
    localparam logic [4:0] REG_CMP_CTRL    = 5'h08;
    localparam logic [4:0] REG_BAUD_LO     = 5'h09;
    localparam logic [4:0] REG_SER_CTRL    = 5'h0A;
    localparam logic [4:0] REG_SER_STAT    = 5'h0B;
    localparam logic [4:0] REG_SER_DATA    = 5'h0C;
    localparam logic [4:0] REG_USER_CTRL   = 5'h0D;
    localparam logic [4:0] REG_USER_STAT   = 5'h0E;
    localparam logic [4:0] REG_USER_DATA   = 5'h0F;
    localparam logic [4:0] REG_PD_PIN      = 5'h10;
    localparam logic [4:0] REG_PD_DIR      = 5'h11;
    localparam logic [4:0] REG_PD_OUT      = 5'h12;
    localparam logic [4:0] REG_SCRATCH0    = 5'h13;
    localparam logic [4:0] REG_SCRATCH1    = 5'h14;
    localparam logic [4:0] REG_SCRATCH2    = 5'h15;
    localparam logic [4:0] REG_PB_PIN      = 5'h16;
    localparam logic [4:0] REG_PB_DIR      = 5'h17;
    localparam logic [4:0] REG_PB_OUT      = 5'h18;
    localparam logic [4:0] REG_PA_PIN      = 5'h19;
    localparam logic [4:0] REG_PA_DIR      = 5'h1A;
    localparam logic [4:0] REG_PA_OUT      = 5'h1B;
    localparam logic [4:0] REG_NVM_CTRL    = 5'h1C;
    localparam logic [4:0] REG_NVM_DATA    = 5'h1D;
    localparam logic [4:0] REG_NVM_ADDR    = 5'h1E;

    // Port widths
    localparam int PA_W   = 3;
    localparam int PB_W   = 8;
    localparam int PD_W   = 7;
    localparam int PIN_W  = PA_W + PB_W + PD_W;

    // ==========================================================================
    // Core commands
    // ==========================================================================
    typedef enum logic [2:0] {
        OP_IO_IN             = 3'h0,
        OP_IO_OUT            = 3'h1,
        OP_DATA_SPACE_LOAD   = 3'h2,
        OP_DATA_SPACE_STORE  = 3'h3,
        OP_SINGLE_BIT_SET    = 3'h4,
        OP_SINGLE_BIT_CLEAR  = 3'h5,
        OP_SKIP_IF_BIT_SET   = 3'h6,
        OP_SKIP_IF_BIT_CLEAR = 3'h7
    } iorsd_op_e;

    // Command classes, used by decode and by write forming
    function automatic logic iorsd_is_bit_op(input iorsd_op_e op);
        return (op == OP_SINGLE_BIT_SET) || (op == OP_SINGLE_BIT_CLEAR) ||
               (op == OP_SKIP_IF_BIT_SET) || (op == OP_SKIP_IF_BIT_CLEAR);
    endfunction

    function automatic logic iorsd_is_write(input iorsd_op_e op);
        return (op == OP_IO_OUT) || (op == OP_DATA_SPACE_STORE) ||
               (op == OP_SINGLE_BIT_SET) || (op == OP_SINGLE_BIT_CLEAR);
    endfunction

    function automatic logic iorsd_is_test(input iorsd_op_e op);
        return (op == OP_SKIP_IF_BIT_SET) || (op == OP_SKIP_IF_BIT_CLEAR);
    endfunction

    // ==========================================================================
    // Per-register bit classes: software-writable, write-one-to-clear, hardware-owned
    // ==========================================================================
    // Reserved addresses fall to the default and hold nothing
    function automatic logic [7:0] iorsd_rw_mask(input logic [4:0] idx);
        case (idx)
            REG_DIG_IN_DIS: return 8'h03;
            REG_BAUD_HI:    return 8'h0F;
            REG_FRAME_CFG:  return 8'h7F;
            REG_CMP_CTRL:   return 8'hCF;
            REG_SER_STAT:   return 8'h03;
            REG_USER_STAT:  return 8'h0F;
            REG_PD_DIR,
            REG_PD_OUT:     return 8'h7F;
            REG_PA_DIR,
            REG_PA_OUT:     return 8'h07;
            REG_NVM_CTRL:   return 8'h3F;
            REG_NVM_ADDR:   return 8'h7F;
            REG_BAUD_LO, REG_SER_CTRL, REG_SER_DATA, REG_USER_CTRL, REG_USER_DATA,
            REG_SCRATCH0, REG_SCRATCH1, REG_SCRATCH2, REG_PB_DIR, REG_PB_OUT,
            REG_NVM_DATA:   return ALL_BITS;
            default:        return NO_BITS;
        endcase
    endfunction

    function automatic logic [7:0] iorsd_w1c_mask(input logic [4:0] idx);
        case (idx)
            REG_CMP_CTRL:  return 8'h10;
            REG_SER_STAT:  return 8'h40;
            REG_USER_STAT: return 8'hE0;
            default:       return NO_BITS;
        endcase
    endfunction

    function automatic logic [7:0] iorsd_ro_mask(input logic [4:0] idx);
        case (idx)
            REG_CMP_CTRL:  return 8'h20;
            REG_SER_STAT:  return 8'hBC;
            REG_USER_STAT: return 8'h10;
            REG_PD_PIN:    return 8'h7F;
            REG_PB_PIN:    return ALL_BITS;
            REG_PA_PIN:    return 8'h07;
            default:       return NO_BITS;
        endcase
    endfunction

endpackage

`default_nettype wire

// >>> pkg/iorsd_bank_if.sv
// Interface between the access decoder and the register storage bank.
// Assumes both ends run on the same clock; the bank registers its read answers.
`default_nettype none

interface iorsd_bank_if;
    import iorsd_pkg::*;

    logic                  we;        // Write strobe, one cycle
    logic [IDX_W-1:0]      waddr;
    logic [DATA_W-1:0]     wmask;     // Bits touched by this write
    logic [DATA_W-1:0]     wval;
    logic                  re;        // Read strobe, one cycle; bit tests use test_en
    logic [IDX_W-1:0]      raddr;
    logic                  test_en;
    logic [2:0]            test_bit;
    logic                  test_pol;  // High: skip when bit is set
    logic [BANK_DEPTH-1:0][DATA_W-1:0] hw_set;
    logic [BANK_DEPTH-1:0][DATA_W-1:0] hw_ro;
    logic [BANK_DEPTH-1:0][DATA_W-1:0] image;
    logic [DATA_W-1:0]     rd_q;
    logic                  test_q;

    modport ctrl (
        output we, waddr, wmask, wval, re, raddr, test_en, test_bit, test_pol,
        output hw_set, hw_ro,
        input  image, rd_q, test_q
    );

    modport bank (
        input  we, waddr, wmask, wval, re, raddr, test_en, test_bit, test_pol,
        input  hw_set, hw_ro,
        output image, rd_q, test_q
    );

endinterface

`default_nettype wire

// >>> rtl/iorsd_bank.sv
// Storage for the 32 bit-accessible I/O registers, with masked writes and registered reads.
// Assumes the decoder forms wmask and wval; hardware set pulses come on the same clock.
`default_nettype none

module iorsd_bank
    import iorsd_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    iorsd_bank_if.bank bus
);

    logic [BANK_DEPTH-1:0][DATA_W-1:0] store_q;
    logic [BANK_DEPTH-1:0][DATA_W-1:0] view;

    // ==========================================================================
    // One storage cell per address
    // ==========================================================================
    generate
        for (genvar i = 0; i < BANK_DEPTH; i++) begin : g_cell
            localparam logic [4:0] IDX   = 5'(i);
            localparam logic [7:0] RW_M  = iorsd_rw_mask(IDX);
            localparam logic [7:0] W1C_M = iorsd_w1c_mask(IDX);
            localparam logic [7:0] RO_M  = iorsd_ro_mask(IDX);
            logic       hit;
            logic [7:0] touch;
            logic [7:0] clr;
            logic [7:0] rw_next;
            logic [7:0] flag_next;

            assign hit   = bus.we && (bus.waddr == IDX);
            // Only bits in wmask are touched, so a bit op leaves neighbours as they are
            assign touch = hit ? bus.wmask : NO_BITS; // RQ6
            assign clr   = touch & bus.wval; // RQ5
            assign rw_next   = ((store_q[i] & ~touch) | (bus.wval & touch)) & RW_M;
            // Hardware set wins over a clear landing in the same cycle
            assign flag_next = ((store_q[i] & ~clr) | bus.hw_set[i]) & W1C_M; // RQ5

            // Masks keep reserved and hardware-owned bits at zero in storage
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    store_q[i] <= RESET_VAL;
                end else begin
                    store_q[i] <= rw_next | flag_next; // RQ9
                end
            end

            // Reserved bits read zero; hardware bits come straight from their owner
            assign view[i] = (store_q[i] & (RW_M | W1C_M)) | (bus.hw_ro[i] & RO_M); // RQ9
        end
    endgenerate

    assign bus.image = store_q;

    // ==========================================================================
    // Registered read and bit test
    // ==========================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.rd_q <= RESET_VAL;
        end else if (bus.re) begin
            bus.rd_q <= view[bus.raddr];
        end else begin
            bus.rd_q <= RESET_VAL;
        end
    end

    // Test result is taken from the same view as a read, so it sees live pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.test_q <= 1'b0;
        end else begin
            bus.test_q <= bus.test_en && (view[bus.raddr][bus.test_bit] == bus.test_pol); // RQ4
        end
    end

endmodule

`default_nettype wire

// >>> rtl/iorsd_top.sv
// Lower I/O register bank: decodes core I/O, data-space and bit commands onto 32 registers.
// Assumes one core request at a time on the core clock; pins arrive asynchronously.
`default_nettype none

module iorsd_top
    import iorsd_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // Core request
    input  wire logic                         io_req,
    input  wire logic [2:0]                   io_op,
    input  wire logic [7:0]                   io_addr,
    input  wire logic [2:0]                   io_bit,
    input  wire logic [DATA_W-1:0]            io_wdata,
    // Core answer
    output logic                              io_ack_q,
    output logic [DATA_W-1:0]                 io_rdata_q,
    output logic                              io_skip_q,
    output logic                              io_upper_q,
    output logic                              io_refused_q,
    // Peripheral side, same clock
    input  wire logic [BANK_DEPTH*DATA_W-1:0] hw_flag_set,
    input  wire logic [BANK_DEPTH*DATA_W-1:0] hw_status,
    output logic [BANK_DEPTH*DATA_W-1:0]      reg_image_q,
    // Port pins
    input  wire logic [PA_W-1:0]              port_a_pin,
    input  wire logic [PB_W-1:0]              port_b_pin,
    input  wire logic [PD_W-1:0]              port_d_pin,
    output logic [PA_W-1:0]                   port_a_out_q,
    output logic [PA_W-1:0]                   port_a_dir_q,
    output logic [PB_W-1:0]                   port_b_out_q,
    output logic [PB_W-1:0]                   port_b_dir_q,
    output logic [PD_W-1:0]                   port_d_out_q,
    output logic [PD_W-1:0]                   port_d_dir_q
);

    iorsd_bank_if bank_bus ();

    iorsd_op_e          op;
    logic               legal;
    logic               is_local;
    logic               is_upper;
    logic [7:0]         io_index;
    logic [DATA_W-1:0]  bit_onehot;
    logic [DATA_W-1:0]  wmask_d;
    logic [DATA_W-1:0]  wval_d;
    logic               do_write;
    logic               do_read;
    logic               do_test;

    logic [PIN_W-1:0]   pin_meta_q;
    logic [PIN_W-1:0]   pin_sync_q;
    logic [PA_W-1:0]    pa_sync;
    logic [PB_W-1:0]    pb_sync;
    logic [PD_W-1:0]    pd_sync;

    logic [BANK_DEPTH-1:0][DATA_W-1:0] status_view;

    assign op = iorsd_op_e'(io_op);

    // ==========================================================================
    // Pin synchronisers
    // ==========================================================================
    // Two flops per pin; only the second is ever read by logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= '0;
        end else begin
            pin_meta_q <= {port_a_pin, port_b_pin, port_d_pin};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_q <= '0;
        end else begin
            pin_sync_q <= pin_meta_q;
        end
    end

    assign pa_sync = pin_sync_q[PIN_W-1 -: PA_W];
    assign pb_sync = pin_sync_q[PD_W +: PB_W];
    assign pd_sync = pin_sync_q[PD_W-1:0];

    // ==========================================================================
    // Hardware-owned read bits
    // ==========================================================================
    // Pin levels override the peripheral status input at the pin addresses
    always_comb begin
        status_view             = hw_status;
        status_view[REG_PA_PIN] = {{(DATA_W-PA_W){1'b0}}, pa_sync};
        status_view[REG_PB_PIN] = pb_sync;
        status_view[REG_PD_PIN] = {{(DATA_W-PD_W){1'b0}}, pd_sync};
    end

    assign bank_bus.hw_ro  = status_view;
    assign bank_bus.hw_set = hw_flag_set;

    // ==========================================================================
    // Address decode
    // ==========================================================================
    // Three views of one bank: I/O, data space shifted by 0x20, and bit access
    always_comb begin
        legal    = 1'b0;
        io_index = 8'h00;
        case (op)
            OP_IO_IN, OP_IO_OUT: begin
                legal    = (io_addr < IO_SPAN); // RQ1
                io_index = io_addr;
            end
            OP_DATA_SPACE_LOAD, OP_DATA_SPACE_STORE: begin
                legal    = (io_addr >= DS_OFFSET) && (io_addr < DS_LIMIT); // RQ2
                io_index = io_addr - DS_OFFSET; // RQ2
            end
            OP_SINGLE_BIT_SET, OP_SINGLE_BIT_CLEAR,
            OP_SKIP_IF_BIT_SET, OP_SKIP_IF_BIT_CLEAR: begin
                // Bit commands stop at the lower half; above it they are refused
                legal    = (io_addr < BIT_SPAN); // RQ3
                io_index = io_addr;
            end
            default: begin
                legal    = 1'b0;
                io_index = 8'h00;
            end
        endcase
    end

    // The upper half belongs to another bank; only the lower half is held here
    assign is_local = io_req && legal && (io_index < BIT_SPAN);
    assign is_upper = io_req && legal && (io_index >= BIT_SPAN);

    // ==========================================================================
    // Write forming
    // ==========================================================================
    assign bit_onehot = DATA_W'(1) << io_bit;

    // A bit command is a write of one bit only: set writes a one, clear a zero.
    // A set landing on a write-one-to-clear flag therefore clears that flag alone.
    always_comb begin
        wmask_d = ALL_BITS;
        wval_d  = io_wdata;
        case (op)
            OP_SINGLE_BIT_SET: begin
                wmask_d = bit_onehot; // RQ6
                wval_d  = ALL_BITS; // RQ3
            end
            OP_SINGLE_BIT_CLEAR: begin
                wmask_d = bit_onehot; // RQ6
                wval_d  = NO_BITS; // RQ3
            end
            default: begin
                wmask_d = ALL_BITS;
                wval_d  = io_wdata;
            end
        endcase
    end

    // Writes to reserved addresses reach the bank but find no storage there
    assign do_write = is_local && iorsd_is_write(op); // RQ8
    assign do_read  = is_local && !iorsd_is_write(op);
    assign do_test  = is_local && iorsd_is_test(op); // RQ4

    assign bank_bus.we       = do_write;
    assign bank_bus.waddr    = io_index[IDX_W-1:0];
    assign bank_bus.wmask    = wmask_d;
    assign bank_bus.wval     = wval_d;
    assign bank_bus.re       = do_read && !iorsd_is_test(op);
    assign bank_bus.raddr    = io_index[IDX_W-1:0];
    assign bank_bus.test_en  = do_test;
    assign bank_bus.test_bit = io_bit;
    assign bank_bus.test_pol = (op == OP_SKIP_IF_BIT_SET); // RQ4

    // ==========================================================================
    // Register storage
    // ==========================================================================
    iorsd_bank u_bank (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (bank_bus)
    );

    // ==========================================================================
    // Core answer
    // ==========================================================================
    // Every request is answered one cycle later, legal or not, so the core never stalls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_ack_q <= 1'b0;
        end else begin
            io_ack_q <= io_req;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_upper_q <= 1'b0;
        end else begin
            io_upper_q <= is_upper; // RQ1
        end
    end

    // Out-of-range views and bit commands above 0x1F are flagged and have no effect
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_refused_q <= 1'b0;
        end else begin
            io_refused_q <= io_req && !legal; // RQ3
        end
    end

    // Read data and test result are the bank's own flops, zero when nothing was read
    assign io_rdata_q = bank_bus.rd_q;
    assign io_skip_q  = bank_bus.test_q;

    // ==========================================================================
    // Register image to peripherals and pins
    // ==========================================================================
    // Outputs are slices of bank flops; no logic sits between storage and pin
    assign reg_image_q  = bank_bus.image;
    assign port_a_out_q = bank_bus.image[REG_PA_OUT][PA_W-1:0];
    assign port_a_dir_q = bank_bus.image[REG_PA_DIR][PA_W-1:0];
    assign port_b_out_q = bank_bus.image[REG_PB_OUT][PB_W-1:0];
    assign port_b_dir_q = bank_bus.image[REG_PB_DIR][PB_W-1:0];
    assign port_d_out_q = bank_bus.image[REG_PD_OUT][PD_W-1:0];
    assign port_d_dir_q = bank_bus.image[REG_PD_DIR][PD_W-1:0];

endmodule

`default_nettype wire

// >>> bench/iorsd_asserts.sv
// Checker on the ports of the lower I/O register bank top.
// Assumes one clock domain and an answer one cycle after each taken request.
`default_nettype none
module iorsd_asserts (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       io_req,
    input wire logic [2:0] io_op,
    input wire logic [7:0] io_addr,
    input wire logic [2:0] io_bit,
    input wire logic       io_ack_q,
    input wire logic [7:0] io_rdata_q,
    input wire logic       io_skip_q,
    input wire logic       io_upper_q,
    input wire logic       io_refused_q,
    input wire logic [7:0] port_b_out_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================================
    // Answer timing, address decode and single-bit writes
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence bset_s;
        io_req && io_op == 3'h4 && io_addr == 8'h18;
    endsequence
    ack_follows_a: assert property (io_req |=> io_ack_q) else $error("ack missing");
    ack_quiet_a: assert property (!io_req |=> !io_ack_q) else $error("stray ack");
    io_range_a: assert property (io_req && io_op < 3'h2 && io_addr >= 8'h40
        |=> io_refused_q) else $error("io range not refused");
    ds_range_a: assert property (io_req && io_op inside {3'h2, 3'h3}
        && (io_addr < 8'h20 || io_addr >= 8'h60) |=> io_refused_q) else $error("ds range");
    upper_half_a: assert property (io_req && ((io_op < 3'h2 && io_addr[7:5] == 3'h1)
        || (io_op inside {3'h2, 3'h3} && io_addr[7:5] == 3'h2)) |=> io_upper_q && !io_refused_q)
        else $error("upper half not flagged");
    bit_range_a: assert property (io_req && io_op >= 3'h4 && io_addr >= 8'h20
        |=> io_refused_q && !io_skip_q) else $error("bit op range");
    skip_tests_a: assert property (io_req && io_op < 3'h6 |=> !io_skip_q)
        else $error("skip on non-test");
    single_bit_a: assert property (bset_s |=> port_b_out_q ==
        ($past(port_b_out_q) | (8'h01 << $past(io_bit)))) else $error("bit set spread");
    rsvd_zero_a: assert property (io_req && io_op == 3'h0 && io_addr inside {8'h00,
        [8'h04:8'h07]} |=> io_rdata_q == 8'h00) else $error("reserved read nonzero");
endmodule
bind iorsd_top iorsd_asserts i_chk (.clk, .rst_n, .io_req, .io_op, .io_addr, .io_bit,
    .io_ack_q, .io_rdata_q, .io_skip_q, .io_upper_q, .io_refused_q, .port_b_out_q);
`default_nettype wire

// >>> bench/iorsd_core_model.sv
// Processor core model issuing one register request at a time.
// Assumes the bank takes a request on a rising edge and answers on the next.
`default_nettype none
module iorsd_core_model (
    input  wire logic  clk,
    output logic       io_req,
    output logic [2:0] io_op,
    output logic [7:0] io_addr,
    output logic [2:0] io_bit,
    output logic [7:0] io_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        io_req = 1'b0;
        io_op = 3'h0;
        io_addr = 8'h00;
        io_bit = 3'h0;
        io_wdata = 8'h00;
    end
    // Callers keep reserved addresses out bar one deliberate case; reserved bits are written in two cases
    task automatic xfer(input logic [2:0] op, input logic [7:0] a, input logic [2:0] b,
                        input logic [7:0] d);
        @(negedge clk);
        io_req = 1'b1;
        io_op = op;
        io_addr = a;
        io_bit = b;
        io_wdata = d;
        @(negedge clk);
        io_req = 1'b0;
        io_addr = ~a; // Idle address never repeats the old value
        io_wdata = ~d; // Return while the answer of this request still stands
    endtask
endmodule
`default_nettype wire

// >>> bench/io_register_space_decode_tb.sv
// Self-checking bench for the lower I/O register bank.
// Assumes the core model in iorsd_core_model and the bound checker.
`default_nettype none
module io_register_space_decode_tb;
    import iorsd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, io_req, io_ack_q, io_skip_q, io_upper_q, io_refused_q;
    logic [2:0] io_op, io_bit, port_a_pin, port_a_dir_q;
    logic [7:0] io_addr, io_wdata, io_rdata_q, port_b_pin, port_b_out_q;
    logic [6:0] port_d_pin, port_d_out_q;
    logic [255:0] hw_flag_set;
    int err_count, samples_checked, cycles;
    iorsd_core_model i_core (.clk, .io_req, .io_op, .io_addr, .io_bit, .io_wdata);
    iorsd_top i_dut (.clk, .rst_n, .io_req, .io_op, .io_addr, .io_bit, .io_wdata,
        .io_ack_q, .io_rdata_q, .io_skip_q, .io_upper_q, .io_refused_q, .hw_flag_set,
        .hw_status('0), .reg_image_q(), .port_a_pin, .port_b_pin, .port_d_pin,
        .port_a_out_q(), .port_a_dir_q, .port_b_out_q, .port_b_dir_q(), .port_d_out_q,
        .port_d_dir_q());
    // ==========================================================================
    // Clock, reset, timeout
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic go(input logic [2:0] op, input logic [7:0] a, input logic [2:0] b,
                      input logic [7:0] d);
        i_core.xfer(op, a, b, d);
        chk("ack", 8'h01, {7'h00, io_ack_q});
    endtask
    // ==========================================================================
    // Scenarios
    task automatic t_views();
        go(3'h1, 8'h13, 3'h0, 8'h5A);
        go(3'h2, 8'h33, 3'h0, 8'h00);
        chk("ds load", 8'h5A, io_rdata_q);
        go(3'h3, 8'h34, 3'h0, 8'hA5);
        go(3'h0, 8'h14, 3'h0, 8'h00);
        chk("io in", 8'hA5, io_rdata_q);
        go(3'h0, 8'h25, 3'h0, 8'h00);
        chk("upper", 8'h01, {7'h00, io_upper_q});
        go(3'h0, 8'h40, 3'h0, 8'h00);
        chk("io refuse", 8'h01, {7'h00, io_refused_q});
        go(3'h2, 8'h1F, 3'h0, 8'h00);
        chk("ds refuse", 8'h01, {7'h00, io_refused_q});
    endtask
    task automatic t_bits();
        go(3'h1, 8'h18, 3'h0, 8'h81);
        go(3'h4, 8'h18, 3'h3, 8'h00);
        chk("bit set", 8'h89, port_b_out_q);
        go(3'h5, 8'h18, 3'h0, 8'h00);
        chk("bit clear", 8'h88, port_b_out_q);
        go(3'h4, 8'h38, 3'h1, 8'h00);
        chk("bit refuse", 8'h01, {7'h00, io_refused_q});
        chk("no change", 8'h88, port_b_out_q);
    endtask
    task automatic t_skip();
        go(3'h6, 8'h16, 3'h0, 8'h00);
        chk("skip set", 8'h01, {7'h00, io_skip_q});
        go(3'h7, 8'h16, 3'h0, 8'h00);
        chk("skip clr", 8'h00, {7'h00, io_skip_q});
        go(3'h7, 8'h16, 3'h1, 8'h00);
        chk("skip clr", 8'h01, {7'h00, io_skip_q});
    endtask
    task automatic t_w1c();
        @(negedge clk);
        hw_flag_set[8*14+5] = 1'b1; // Raise a flag in the user status register
        @(negedge clk);
        hw_flag_set = '0;
        go(3'h1, 8'h0E, 3'h0, 8'h00);
        go(3'h0, 8'h0E, 3'h0, 8'h00);
        chk("zero keeps", 8'h20, io_rdata_q);
        go(3'h4, 8'h0E, 3'h0, 8'h00);
        go(3'h0, 8'h0E, 3'h0, 8'h00);
        chk("set spares", 8'h21, io_rdata_q);
        go(3'h1, 8'h0E, 3'h0, 8'h21);
        go(3'h0, 8'h0E, 3'h0, 8'h00);
        chk("one clears", 8'h01, io_rdata_q);
    endtask
    task automatic t_rsvd();
        go(3'h1, 8'h05, 3'h0, 8'hFF); // Deliberately breaks the no-write rule
        go(3'h0, 8'h05, 3'h0, 8'h00);
        chk("rsvd addr", 8'h00, io_rdata_q);
        go(3'h1, 8'h1A, 3'h0, 8'hFF);
        chk("rsvd bits", 8'h07, {5'h00, port_a_dir_q});
        go(3'h0, 8'h19, 3'h0, 8'h00);
        chk("pin read", 8'h05, io_rdata_q);
        go(3'h1, 8'h12, 3'h0, 8'hFF);
        chk("pd out", 8'h7F, {1'b0, port_d_out_q});
    endtask
    initial begin
        rst_n = 1'b0;
        hw_flag_set = '0;
        port_a_pin = 3'h5;
        port_b_pin = 8'h05;
        port_d_pin = 7'h00;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_views();
        t_bits();
        t_skip();
        t_w1c();
        t_rsvd();
        wrap_up();
    end
endmodule
`default_nettype wire
